// ---- hw/pamux_ahb.sv ----
// AHB-Lite slave front end: captures the address phase.
// Assumes a single slave, word transfers; the top adds one wait state to reads.
`timescale 1ns/1ns
module pamux_ahb
    import pamux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [7:0] haddr,
    output logic wr_pend,
    output logic rd_pend,
    output logic [7:0] addr_q
);
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend <= hsel && htrans[1] && hwrite;
            rd_pend <= hsel && htrans[1] && !hwrite;
            addr_q <= haddr;
        end
    end
endmodule : pamux_ahb

// ---- hw/pamux_clkdiv.sv ----
// Quarter-rate clock out generator for line six.
// Assumes the oscillator input rate is the block clock.
`timescale 1ns/1ns
module pamux_clkdiv
    import pamux_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    output logic clk_q
);
`include "pamux_defines.svh"
    logic [1:0] cnt;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt <= 2'h0;
        else
            cnt <= (cnt == `PAMUX_CLKDIV_MAX) ? 2'h0 : cnt + 2'h1;
    end
    assign clk_q = (cnt > `PAMUX_CLKDIV_HALF);
endmodule : pamux_clkdiv

// ---- hw/pamux_defines.svh ----
// Constants for the port A upper-line pin multiplexer.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
// Functional notes
// - After reset line four is a digital input with its driver off.
// - An enabled compare unit five output drives line four ahead of the latch.
// - An enabled SR latch true output drives line four ahead of compare five and the latch.
// - With direction input, line four feeds the capture input through a Schmitt buffer.
// - With direction input, line four also feeds the timer zero external clock.
// - Line five's digital input reads zero while its analog select is set.
// - With direction output, line five drives its latch, or an enabled SR latch inverted or comparator two output, whatever its analog select.
// - With direction input and analog off, line five gives the serial one slave select.
// - Line six is plain I/O only in internal oscillator mode without clock out.
// - In RC mode line six drives a clock at a quarter of the oscillator input rate.
// - In external oscillator modes line seven's digital output and input are off.
// - Unimplemented register bits read as zero.
// - With several outputs enabled on one pin, the highest priority one wins.
// - The direction register controls the drivers even on analog pins.
// - After reset lines five and zero to three are analog and read zero.
`ifndef PAMUX_DEFINES_SVH
`define PAMUX_DEFINES_SVH
`define PAMUX_OFF_PINS 8'h00
`define PAMUX_OFF_LATCH 8'h04
`define PAMUX_OFF_DIR 8'h08
`define PAMUX_OFF_ANSEL 8'h0C
`define PAMUX_OFF_SLEW 8'h10
`define PAMUX_OFF_MODE 8'h14
`define PAMUX_RST_DIR 8'hFF
`define PAMUX_RST_ANSEL 8'h2F
`define PAMUX_RST_LATCH 8'h00
`define PAMUX_RST_SLEW 8'h00
`define PAMUX_RST_MODE 8'h00
`define PAMUX_ANSEL_MASK 8'h2F
`define PAMUX_SLEW_MASK 8'h1F
`define PAMUX_MODE_MASK 8'h1F
`define PAMUX_MODE_OSC_LSB 0
`define PAMUX_MODE_CLOCK_OUT_FUNCTION_BIT 2
`define PAMUX_MODE_CCP_BIT 3
`define PAMUX_MODE_SRQ_BIT 4
`define PAMUX_CLKDIV_MAX 2'h3
`define PAMUX_CLKDIV_HALF 2'h1
`endif

// ---- hw/pamux_pkg.sv ----
// Types for the port A upper-line pin multiplexer.
// Assumes pamux_defines.svh is on the include path.
package pamux_pkg;
    typedef enum logic [1:0] {PAMUX_OSC_INT, PAMUX_OSC_RC, PAMUX_OSC_XTAL, PAMUX_OSC_EXT} pamux_osc_t;
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] ansel;
        logic [1:0] osc;
        logic clock_out_function_en;
        logic ccp_en;
        logic srq_en;
    } pamux_cfg_t;
    typedef struct packed {
        logic ccp_out;
        logic sr_latch_true_out;
        logic sr_latch_inverted_out;
        logic comparator_one_output;
        logic comparator_two_output;
        logic sr_latch_inverted_out_en;
        logic c1oe;
        logic c2oe;
    } pamux_periph_t;
endpackage : pamux_pkg

// ---- hw/pamux_top.sv ----
// Port A upper lines four to seven: pin mux, direction, analog select, registers.
// Assumes pin inputs are already synchronous to REF_CLK and AHB-Lite as sole master.
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module pamux_top
    import pamux_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [7:0] PIN_IN,
    output logic [7:0] PIN_OUT,
    output logic [7:0] PIN_OE,
    input wire logic [7:0] PERIPH_IN,
    output logic CAPTURE_IN,
    output logic TIMER_ZERO_EXT_CLOCK,
    output logic SERIAL_ONE_SLAVE_SELECT
);
`include "pamux_defines.svh"
    pamux_cfg_t cfg;
    pamux_periph_t per;
    logic [7:0] slew;
    logic [7:0] pins;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic clk_q;
    logic [7:0] next_out;
    logic [7:0] next_oe;
    logic [7:0] dig_in_en;
    logic [7:0] rd_val;
    logic [7:0] mode_rd;
    logic int_osc;
    logic rc_mode;
    logic ext_osc;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] ansel;
    logic [1:0] osc;
    logic clock_out_function_en;
    logic ccp_en;
    logic srq_en;
    logic rd_start;

    function automatic logic [7:0] wr_field(input logic [31:0] d, input logic [7:0] mask);
        wr_field = d[7:0] & mask;
    endfunction : wr_field

    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_pend && (addr_q == off);
    endfunction : wr_hit

    function automatic logic gate_in(input logic en, input logic lvl, input logic idle);
        gate_in = en ? lvl : idle;
    endfunction : gate_in

    assign per = pamux_periph_t'(PERIPH_IN);
    assign int_osc = (pamux_osc_t'(cfg.osc) == PAMUX_OSC_INT);
    assign rc_mode = (pamux_osc_t'(cfg.osc) == PAMUX_OSC_RC);
    assign ext_osc = !int_osc && !rc_mode;
    assign cfg = {latch, dir, ansel, osc, clock_out_function_en, ccp_en, srq_en};
    // Read address phase accepted this edge
    assign rd_start = HSEL && HTRANS[1] && !HWRITE && HREADY;
    assign mode_rd = {3'h0, cfg.srq_en, cfg.ccp_en, cfg.clock_out_function_en, cfg.osc};

    pamux_ahb u_ahb (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .hsel(HSEL),
        .htrans(HTRANS),
        .hwrite(HWRITE),
        .hready(HREADY),
        .haddr(HADDR[7:0]),
        .wr_pend(wr_pend),
        .rd_pend(rd_pend),
        .addr_q(addr_q)
    );

    pamux_clkdiv u_div (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .clk_q(clk_q)
    );

    // Output latch, written through both the pin and latch offsets
    // Writing pins lands in the latch; read-modify-write through the latch offset never copies pin levels
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            latch <= `PAMUX_RST_LATCH;
        else if (wr_hit(`PAMUX_OFF_PINS) || wr_hit(`PAMUX_OFF_LATCH))
            latch <= HWDATA[7:0];
    end

    // Direction register
    // All lines start as inputs so analog pins come up undriven
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            dir <= `PAMUX_RST_DIR;
        else if (wr_hit(`PAMUX_OFF_DIR))
            dir <= HWDATA[7:0];
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            ansel <= `PAMUX_RST_ANSEL;
        else if (wr_hit(`PAMUX_OFF_ANSEL))
            ansel <= wr_field(HWDATA, `PAMUX_ANSEL_MASK);
    end

    // Slew bits stored only; no pad behaviour here
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            slew <= `PAMUX_RST_SLEW;
        else if (wr_hit(`PAMUX_OFF_SLEW))
            slew <= wr_field(HWDATA, `PAMUX_SLEW_MASK);
    end

    // Mode fields; lines zero to three ignore them
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            osc <= 2'h0;
            clock_out_function_en <= 1'b0;
            ccp_en <= 1'b0;
            srq_en <= 1'b0;
        end
        else if (wr_hit(`PAMUX_OFF_MODE))
        begin
            osc <= HWDATA[`PAMUX_MODE_OSC_LSB +: 2];
            clock_out_function_en <= HWDATA[`PAMUX_MODE_CLOCK_OUT_FUNCTION_BIT];
            ccp_en <= HWDATA[`PAMUX_MODE_CCP_BIT];
            srq_en <= HWDATA[`PAMUX_MODE_SRQ_BIT];
        end
    end

    // Output selection and enables
    always_comb
    begin
        next_out = cfg.latch;
        // Direction rules drivers, analog or not
        next_oe = ~cfg.dir;
        if (cfg.srq_en)
            next_out[4] = per.sr_latch_true_out;
        else if (per.c1oe)
            next_out[4] = per.comparator_one_output;
        else if (cfg.ccp_en)
            next_out[4] = per.ccp_out;
        if (per.sr_latch_inverted_out_en)
            next_out[5] = per.sr_latch_inverted_out;
        else if (per.c2oe)
            next_out[5] = per.comparator_two_output;
        // Quarter rate clock out in RC mode
        if (rc_mode || (int_osc && cfg.clock_out_function_en))
        begin
            next_out[6] = clk_q;
            next_oe[6] = 1'b1;
        end
        // Line six plain I/O only internal no clock out
        else if (!int_osc)
            next_oe[6] = 1'b0;
        if (ext_osc)
            next_oe[7] = 1'b0;
    end

    // Digital input enables
    always_comb
    begin
        dig_in_en = ~cfg.ansel;
        // Line six input only as plain I/O
        if (!int_osc || cfg.clock_out_function_en)
            dig_in_en[6] = 1'b0;
        if (ext_osc)
            dig_in_en[7] = 1'b0;
    end

    // Pin drive
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            PIN_OUT <= 8'h00;
            PIN_OE <= 8'h00;
        end
        else
        begin
            PIN_OUT <= next_out;
            PIN_OE <= next_oe;
        end
    end

    // Sampled levels for the pin register
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            pins <= 8'h00;
        else
            pins <= PIN_IN & dig_in_en;
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            CAPTURE_IN <= 1'b0;
        else
            CAPTURE_IN <= gate_in(cfg.dir[4], PIN_IN[4], 1'b0);
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            TIMER_ZERO_EXT_CLOCK <= 1'b0;
        else
            TIMER_ZERO_EXT_CLOCK <= gate_in(cfg.dir[4], PIN_IN[4], 1'b0);
    end

    // Slave select from line five
    // Idles deselected so the serial port never sees a false select
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            SERIAL_ONE_SLAVE_SELECT <= 1'b1;
        else
            SERIAL_ONE_SLAVE_SELECT <= gate_in(cfg.dir[5] && !cfg.ansel[5], PIN_IN[5], 1'b1);
    end

    // Read mux
    always_comb
    begin
        case (addr_q)
            `PAMUX_OFF_PINS: rd_val = pins;
            `PAMUX_OFF_LATCH: rd_val = cfg.latch;
            `PAMUX_OFF_DIR: rd_val = cfg.dir;
            `PAMUX_OFF_ANSEL: rd_val = cfg.ansel;
            `PAMUX_OFF_SLEW: rd_val = slew;
            `PAMUX_OFF_MODE: rd_val = mode_rd;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            HRDATA <= 32'h0000_0000;
        else
            HRDATA <= {24'h00_0000, rd_val};
    end

    // One wait state on reads: registered read data then stands in the data phase
    // Costs a cycle per read, writes stay at zero wait
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            HREADYOUT <= 1'b1;
        else
            HREADYOUT <= !rd_start;
    end

    // Always OKAY
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            HRESP <= 1'b0;
        else
            HRESP <= 1'b0;
    end
endmodule : pamux_top

// ---- tb/pamux_pins.sv ----
// Model of the circuits on the port pins.
// Assumes the bench sets the undriven pin levels.
`timescale 1ns/1ns
module pamux_pins
(
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext,
    output logic [7:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pamux_pins

// ---- tb/pamux_properties.sv ----
// Port checker for pamux_top.
// Assumes it is bound into pamux_top.
`timescale 1ns/1ns
module pamux_properties
(
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [7:0] PIN_IN,
    input wire logic [7:0] PIN_OUT,
    input wire logic [7:0] PIN_OE,
    input wire logic CAPTURE_IN,
    input wire logic TIMER_ZERO_EXT_CLOCK,
    input wire logic SERIAL_ONE_SLAVE_SELECT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_rel;
        $rose(RST_B);
    endsequence
    // Two rises four apart mean the divider runs
    sequence s_q_rise;
        (PIN_OE[6] && $rose(PIN_OUT[6])) ##4 $rose(PIN_OUT[6]);
    endsequence
    a_reset_idle: assert property (s_rel |-> PIN_OE == 8'h00 && SERIAL_ONE_SLAVE_SELECT)
        else $error("drivers on after reset");
    a_cap_src: assert property (CAPTURE_IN |-> $past(PIN_IN[4]))
        else $error("capture input not from pin");
    a_timer_cap: assert property (TIMER_ZERO_EXT_CLOCK == CAPTURE_IN)
        else $error("timer clock differs from pin path");
    a_ss_src: assert property (!SERIAL_ONE_SLAVE_SELECT |-> !$past(PIN_IN[5]))
        else $error("slave select not from pin");
    a_out4_nocap: assert property (PIN_OE[4] |-> !CAPTURE_IN)
        else $error("capture active on output line");
    a_out5_noss: assert property (PIN_OE[5] |-> SERIAL_ONE_SLAVE_SELECT)
        else $error("slave select active on output line");
    a_upper_zero: assert property (HRDATA[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_clock_quarter: assert property (s_q_rise |-> ##4 $rose(PIN_OUT[6]))
        else $error("clock out period not four");
    a_read_wait: assert property (!HREADYOUT |=> HREADYOUT)
        else $error("read wait longer than one cycle");
    a_resp_okay: assert property (!HRESP)
        else $error("error response seen");
endmodule : pamux_properties
bind pamux_top pamux_properties props_u (.*);

// ---- tb/port_a_upper_pin_mux_tb.sv ----
// Bench: bus master, pin partner and scoreboard.
// Assumes one clock; the master waits on hready for every phase.
`timescale 1ns/1ns
module port_a_upper_pin_mux_tb
    import pamux_pkg::*;
;
    logic ref_clk, rst_b, hsel, hwrite, hrdy, hresp, cap, tmr, ss;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, robs;
    logic [7:0] pin_in, pin_out, pin_oe, ext, lat, dir, ans, mode;
    pamux_periph_t per;
    logic [31:0] exp_q[$];
    logic [10:0] pin_q[$];
    event rd_ev, pin_ev;
    int num_errors = 0;
    int n_checks = 0;
    logic [7:0] ra [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [7:0] rv [6] = '{8'h00, 8'hFF, 8'h2F, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk [6] = '{8'hFF, 8'hFF, 8'h2F, 8'h1F, 8'h1F, 8'h00};
    pamux_top dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PERIPH_IN(per), .CAPTURE_IN(cap), .TIMER_ZERO_EXT_CLOCK(tmr),
        .SERIAL_ONE_SLAVE_SELECT(ss));
    pamux_pins pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task finish_test;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task cmp_reg(input logic [31:0] e, input logic [31:0] o);
        n_checks++;
        if (o !== e)
        begin
            num_errors++;
            $display("BAD hrdata exp %h got %h", e, o);
        end
    endtask : cmp_reg
    task cmp_pin(input logic [10:0] e, input logic [10:0] o);
        n_checks++;
        if (o !== e)
        begin
            num_errors++;
            $display("BAD pins exp %h got %h", e, o);
        end
    endtask : cmp_pin
    initial forever
    begin
        @(rd_ev);
        cmp_reg(exp_q.pop_front(), robs);
    end
    // Sample once the edge's updates have landed
    initial forever
    begin
        @(pin_ev);
        #1;
        cmp_pin(pin_q[0], {cap, tmr, ss, pin_oe[7:4], pin_out[7:4] & pin_q[0][7:4]});
        void'(pin_q.pop_front());
    end
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        @(posedge ref_clk);
        while (hrdy !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hrdy !== 1'b1) @(posedge ref_clk);
        // Read data taken at the edge that ends the data phase
        robs = hrdata;
    endtask : bus
    task note(input logic [31:0] e, input logic [31:0] o);
        exp_q.push_back(e);
        robs = o;
        -> rd_ev;
    endtask : note
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        note(e, robs);
    endtask : rd
    task cfg;
        bus(1'b1, 8'h04, {24'h00_0000, lat});
        bus(1'b1, 8'h08, {24'h00_0000, dir});
        bus(1'b1, 8'h0C, {24'h00_0000, ans});
        bus(1'b1, 8'h14, {24'h00_0000, mode});
        repeat (3) @(posedge ref_clk);
    endtask : cfg
    function automatic logic [10:0] exp_pins();
        logic [3:0] oe;
        logic [3:0] o;
        oe = {!mode[1] & !dir[7], mode[2:0] == 3'h0 && !dir[6], !dir[5], !dir[4]};
        o = {lat[7:6], per.sr_latch_inverted_out_en ? per.sr_latch_inverted_out : per.c2oe ? per.comparator_two_output : lat[5],
            mode[4] ? per.sr_latch_true_out : per.c1oe ? per.comparator_one_output : mode[3] ? per.ccp_out : lat[4]};
        return {dir[4] & ext[4], dir[4] & ext[4], !dir[5] | ans[5] | ext[5], oe, o & oe};
    endfunction : exp_pins
    task pchk;
        pin_q.push_back(exp_pins());
        -> pin_ev;
    endtask : pchk
    initial
    begin
        logic [10:0] e;
        logic [7:0] lvl;
        logic [31:0] cnt;
        logic prv;
        rst_b = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        per = 8'h00;
        ext = 8'hFF;
        lat = 8'h00;
        dir = 8'hFF;
        ans = 8'h2F;
        mode = 8'h00;
        void'($urandom(32'hf51e));
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        pchk();
        rd(8'h00, 32'h0000_00D0);
        foreach (ra[i])
        begin
            rd(ra[i], {24'h00_0000, rv[i]});
            bus(1'b1, ra[i], 32'hFFFF_FFFF);
            rd(ra[i], {24'h00_0000, mk[i]});
        end
        // Bit six kept still so a stray rise never mimics the clock
        repeat (16)
        begin
            lat = 8'($urandom) & 8'hBF;
            dir = {4'($urandom), 4'hF};
            ans = 8'($urandom) & 8'h2F;
            mode = 8'($urandom) & 8'h1B;
            if (mode[1:0] == 2'h1)
                mode[0] = 1'b0;
            per <= 8'($urandom);
            ext <= 8'($urandom);
            cfg();
            pchk();
            rd(8'h04, {24'h00_0000, lat});
            e = exp_pins();
            lvl = {(e[7:4] & e[3:0]) | (~e[7:4] & ext[7:4]), ext[3:0]};
            rd(8'h00, {24'h00_0000, lvl & ~ans & (mode[1] ? 8'h3F : 8'hFF)});
        end
        for (int k = 0; k < 2; k++)
        begin
            mode = k ? 8'h04 : 8'h01;
            cfg();
            cnt = 32'h0000_0000;
            prv = pin_out[6];
            repeat (16)
            begin
                @(posedge ref_clk);
                cnt += 32'(pin_oe[6] & pin_out[6] & !prv);
                prv = pin_out[6];
            end
            note(32'h0000_0004, cnt);
        end
        @(posedge ref_clk);
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        finish_test();
    end
endmodule : port_a_upper_pin_mux_tb
